// [logic/rsd_defs.vh]
// Constants for the rail sequence delay register bank
`ifndef RSD_DEFS_VH
`define RSD_DEFS_VH

// ----------------------------------------------------------------
// Register sub-addresses
// ----------------------------------------------------------------
`define RSD_ADDR_AUX_VOLT   8'h1B
`define RSD_ADDR_SEQ_LOW    8'h20
`define RSD_ADDR_SEQ_HIGH   8'h21

// ----------------------------------------------------------------
// Reset values and field layout
// ----------------------------------------------------------------
`define RSD_RST_AUX_VOLT    6'h1F
`define RSD_RST_SEQ_LOW     8'h00
`define RSD_RST_SEQ_HIGH    8'h00
`define RSD_VOLT_MSB        5
`define RSD_SCALE_BIT       7
`define RSD_GAP9_BIT        0
`define RSD_READ_ZERO       8'h00

// ----------------------------------------------------------------
// Voltage decode, millivolts
// ----------------------------------------------------------------
`define RSD_FINE_BASE_MV    12'h384
`define RSD_FINE_STEP_MV    12'h019
`define RSD_FINE_LAST_CODE  6'h19
`define RSD_COARSE_CODE     6'h1A
`define RSD_COARSE_BASE_MV  12'h60E
`define RSD_COARSE_STEP_MV  12'h032

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define RSD_CLK_MHZ         50
`define RSD_GAP_SHORT_US    2000
`define RSD_GAP_LONG_US     5000
`define RSD_BLANK_US        5000
`define RSD_PD_SCALE        10
`define RSD_GAP_FIRST       4'h1
`define RSD_GAP_LAST        4'h9

`endif

// [logic/rsd_gap_timer.v]
// Down counter that times one sequencer strobe gap
`timescale 1ns/1ns
module rsd_gap_timer
#(
  parameter CNT_W = 24
)
(
  // Clock and reset
  input  wire             sys_clk_in,
  input  wire             rstn_in,
  // Control
  input  wire             start_in,
  input  wire [CNT_W-1:0] len_in,
  // Status
  output wire             busy_out,
  output wire             done_out
);

  reg  [CNT_W-1:0] cnt_r;
  reg  [CNT_W-1:0] cnt_nxt;
  reg              done_r;
  reg              done_nxt;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // A new start restarts the gap even mid-count
  always @*
  begin
    cnt_nxt  = cnt_r;
    done_nxt = 1'b0;
    if (start_in)
    begin
      cnt_nxt = len_in;
    end
    else if (cnt_r != {CNT_W{1'b0}})
    begin
      cnt_nxt = cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
      if (cnt_r == {{(CNT_W-1){1'b0}}, 1'b1})
      begin
        done_nxt = 1'b1;
      end
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      cnt_r  <= {CNT_W{1'b0}};
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r  <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign busy_out = (cnt_r != {CNT_W{1'b0}});
  assign done_out = done_r;

endmodule

// [logic/rsd_regs.v]
// Regulator setpoint and sequencer delay register bank
`timescale 1ns/1ns
`include "rsd_defs.vh"

module rsd_regs
#(
  parameter SHORT_CYC = `RSD_GAP_SHORT_US * `RSD_CLK_MHZ,
  parameter LONG_CYC  = `RSD_GAP_LONG_US * `RSD_CLK_MHZ,
  parameter BLANK_CYC = `RSD_BLANK_US * `RSD_CLK_MHZ,
  parameter PD_SCALE  = `RSD_PD_SCALE,
  parameter CNT_W     = 24
)
(
  // Clock and reset
  input  wire             sys_clk_in,
  input  wire             rstn_in,
  // Register port from the serial slave
  input  wire             reg_wr_in,
  input  wire             reg_rd_in,
  input  wire [7:0]       reg_addr_in,
  input  wire [7:0]       reg_wdata_in,
  output wire [7:0]       reg_rdata_out,
  output wire             reg_wr_refused_out,
  // Unlock level from the password logic
  input  wire             unlock_in,
  // Regulator setpoint
  output wire [5:0]       aux_regulator_voltage_out,
  output wire [11:0]      aux_voltage_mv_out,
  output wire             monitor_blank_out,
  // Sequencer gap timing
  output wire [8:0]       gap_select_out,
  output wire             powerdown_gap_scale_out,
  input  wire             gap_start_in,
  input  wire [3:0]       gap_index_in,
  input  wire             power_down_in,
  output wire             gap_busy_out,
  output wire             gap_done_out
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function hit;
    input [7:0] addr;
    input [7:0] target;
    begin
      hit = (addr == target);
    end
  endfunction

  localparam [CNT_W-1:0] SHORT_LEN = SHORT_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] LONG_LEN  = LONG_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] BLANK_LEN = BLANK_CYC[CNT_W-1:0];
  // Scaled lengths must still fit CNT_W bits
  localparam integer     SHORT_PD_CYC = SHORT_CYC * PD_SCALE;
  localparam integer     LONG_PD_CYC  = LONG_CYC * PD_SCALE;
  localparam [CNT_W-1:0] SHORT_PD  = SHORT_PD_CYC[CNT_W-1:0];
  localparam [CNT_W-1:0] LONG_PD   = LONG_PD_CYC[CNT_W-1:0];
  localparam [7:0]       SEQ_HIGH_RST = `RSD_RST_SEQ_HIGH;

  reg  [5:0]       aux_volt_r;
  reg  [7:0]       seq_low_r;
  reg              gap9_r;
  reg              scale_r;
  reg  [7:0]       rdata_r;
  reg  [7:0]       rdata_nxt;
  reg              refused_r;
  reg  [CNT_W-1:0] blank_r;
  reg  [11:0]      volt_mv_r;
  reg  [11:0]      volt_mv_nxt;
  reg              gap_long;
  reg  [CNT_W-1:0] gap_len;

  wire             wr_volt;
  wire             wr_low;
  wire             wr_high;
  wire [8:0]       gap_sel;

  assign wr_volt = reg_wr_in & hit(reg_addr_in, `RSD_ADDR_AUX_VOLT);
  assign wr_low  = reg_wr_in & hit(reg_addr_in, `RSD_ADDR_SEQ_LOW);
  assign wr_high = reg_wr_in & hit(reg_addr_in, `RSD_ADDR_SEQ_HIGH);

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      aux_volt_r <= `RSD_RST_AUX_VOLT;
      seq_low_r  <= `RSD_RST_SEQ_LOW;
      gap9_r     <= SEQ_HIGH_RST[`RSD_GAP9_BIT];
      scale_r    <= SEQ_HIGH_RST[`RSD_SCALE_BIT];
      refused_r  <= 1'b0;
    end
    else
    begin
      // Upper bits dropped on write
      if (wr_volt)
      begin
        aux_volt_r <= reg_wdata_in[`RSD_VOLT_MSB:0];
      end
      if (wr_low && unlock_in)
      begin
        seq_low_r <= reg_wdata_in;
      end
      // Bits 6..1 are not stored at all
      if (wr_high && unlock_in)
      begin
        gap9_r  <= reg_wdata_in[`RSD_GAP9_BIT];
        scale_r <= reg_wdata_in[`RSD_SCALE_BIT];
      end
      refused_r <= (wr_low | wr_high) & ~unlock_in;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always @*
  begin
    rdata_nxt = rdata_r;
    if (reg_rd_in)
    begin
      if (hit(reg_addr_in, `RSD_ADDR_AUX_VOLT))
      begin
        rdata_nxt = {2'h0, aux_volt_r};
      end
      else if (hit(reg_addr_in, `RSD_ADDR_SEQ_LOW))
      begin
        rdata_nxt = seq_low_r;
      end
      else if (hit(reg_addr_in, `RSD_ADDR_SEQ_HIGH))
      begin
        rdata_nxt = {scale_r, 6'h00, gap9_r};
      end
      else
      begin
        rdata_nxt = `RSD_READ_ZERO;
      end
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      rdata_r <= `RSD_READ_ZERO;
    end
    else
    begin
      rdata_r <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Setpoint decode
  // ----------------------------------------------------------------
  // Registered so the analog side sees one clean code change
  always @*
  begin
    if (aux_volt_r <= `RSD_FINE_LAST_CODE)
    begin
      volt_mv_nxt = `RSD_FINE_BASE_MV
                  + `RSD_FINE_STEP_MV * {6'h00, aux_volt_r};
    end
    else
    begin
      volt_mv_nxt = `RSD_COARSE_BASE_MV + `RSD_COARSE_STEP_MV
                  * {6'h00, aux_volt_r - `RSD_COARSE_CODE};
    end
  end

  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      volt_mv_r <= 12'h000;
    end
    else
    begin
      volt_mv_r <= volt_mv_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Monitor blanking
  // ----------------------------------------------------------------
  // Every write restarts the window, even with an unchanged code
  always @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      blank_r <= {CNT_W{1'b0}};
    end
    else if (wr_volt)
    begin
      blank_r <= BLANK_LEN;
    end
    else if (blank_r != {CNT_W{1'b0}})
    begin
      blank_r <= blank_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // Gap length selection
  // ----------------------------------------------------------------
  assign gap_sel = {gap9_r, seq_low_r};

  // Indexes outside 1..9 fall back to the short gap
  always @*
  begin
    gap_long = 1'b0;
    if (gap_index_in >= `RSD_GAP_FIRST && gap_index_in <= `RSD_GAP_LAST)
    begin
      gap_long = gap_sel[gap_index_in - `RSD_GAP_FIRST];
    end
    case ({power_down_in & scale_r, gap_long})
      2'b00:   gap_len = SHORT_LEN;
      2'b01:   gap_len = LONG_LEN;
      2'b10:   gap_len = SHORT_PD;
      2'b11:   gap_len = LONG_PD;
      default: gap_len = SHORT_LEN;
    endcase
  end

  rsd_gap_timer #(
    .CNT_W      (CNT_W)
  ) u_gap_timer (
    .sys_clk_in (sys_clk_in),
    .rstn_in    (rstn_in),
    .start_in   (gap_start_in),
    .len_in     (gap_len),
    .busy_out   (gap_busy_out),
    .done_out   (gap_done_out)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_out             = rdata_r;
  assign reg_wr_refused_out        = refused_r;
  assign aux_regulator_voltage_out = aux_volt_r;
  assign aux_voltage_mv_out        = volt_mv_r;
  assign monitor_blank_out         = (blank_r != {CNT_W{1'b0}});
  assign gap_select_out            = gap_sel;
  assign powerdown_gap_scale_out   = scale_r;

endmodule

// [test/rsd_host.sv]
// Host model driving the register byte port
`timescale 1ns/1ns
module rsd_host
(
  // Clock and read data
  input  wire logic       sys_clk_in,
  input  wire logic [7:0] reg_rdata_in,
  // Requests
  output logic            reg_wr_out,
  output logic            reg_rd_out,
  output logic [7:0]      reg_addr_out,
  output logic [7:0]      reg_wdata_out,
  output logic            unlock_out
);
  initial
    {reg_wr_out, reg_rd_out, reg_addr_out, reg_wdata_out, unlock_out} = '0;
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
    @(negedge sys_clk_in);
    unlock_out = u;
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'b1;
    @(negedge sys_clk_in);
    reg_wr_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    @(negedge sys_clk_in);
    reg_addr_out = a;
    reg_rd_out = 1'b1;
    @(negedge sys_clk_in);
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    q = reg_rdata_in;
  endtask
endmodule

// [test/rsd_regs_bench.sv]
// Self-checking bench for the register bank
`timescale 1ns/1ns
`include "rsd_defs.vh"
module rsd_regs_bench;
  logic        sys_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        gap_start_in = 1'b0;
  logic [3:0]  gap_index_in = 4'h0;
  logic        power_down_in = 1'b0;
  wire         reg_wr_in, reg_rd_in, unlock_in, reg_wr_refused_out;
  wire         monitor_blank_out, powerdown_gap_scale_out;
  wire         gap_busy_out, gap_done_out;
  wire  [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  wire  [5:0]  aux_regulator_voltage_out;
  wire  [11:0] aux_voltage_mv_out;
  wire  [8:0]  gap_select_out;
  logic [7:0]  a, d, q;
  logic [7:0]  addrs [4] = '{8'h1B, 8'h20, 8'h21, 8'h22};
  logic [5:0]  m_volt = 6'h1F;
  logic [8:0]  m_sel = 9'h000;
  logic        m_scale = 1'b0;
  logic        u, lk;
  int          err_count = 0;
  int          total_checks = 0;
  int          n;

  always #10 sys_clk_in = ~sys_clk_in;

  rsd_host host (.sys_clk_in, .reg_rdata_in(reg_rdata_out),
    .reg_wr_out(reg_wr_in), .reg_rd_out(reg_rd_in),
    .reg_addr_out(reg_addr_in), .reg_wdata_out(reg_wdata_in),
    .unlock_out(unlock_in));
  rsd_regs #(.SHORT_CYC(4), .LONG_CYC(10), .BLANK_CYC(8), .PD_SCALE(10))
    dut (.*);

  function automatic logic [11:0] mv_f(input logic [5:0] c);
    return (c <= 6'h19) ? 12'h384 + 12'h019 * c
                        : 12'h60E + 12'h032 * (c - 6'h1A);
  endfunction
  function automatic logic [7:0] rd_f(input logic [7:0] x);
    case (x)
      8'h1B:   return {2'b00, m_volt};
      8'h20:   return m_sel[7:0];
      8'h21:   return {m_scale, 6'h00, m_sel[8]};
      default: return 8'h00;
    endcase
  endfunction
  function automatic int len_f(input logic [3:0] i, input logic p);
    len_f = (i >= 4'h1 && i <= 4'h9 && m_sel[i - 4'h1]) ? 10 : 4;
    if (p && m_scale)
      len_f = len_f * 10;
  endfunction
  task automatic chk(input string nm, input logic [11:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    #200000;
    err_count++;
    test_done;
  end

  initial
  begin
    void'($urandom(78));
    repeat (10) @(negedge sys_clk_in);
    rstn_in = 1'b1;
    foreach (addrs[k])
    begin
      host.rd(addrs[k], q);
      chk("reset read", q, rd_f(addrs[k]));
    end
    chk("reset mv", aux_voltage_mv_out, 12'h708);
    for (int c = 0; c < 64; c++)
    begin
      host.wr(8'h1B, 8'(c) | 8'hC0, 1'b0);
      @(negedge sys_clk_in);
      chk("decode", aux_voltage_mv_out, mv_f(6'(c)));
    end
    m_volt = 6'h3F;
    for (int i = 0; i < 40; i++)
    begin
      a = addrs[$urandom % 4];
      d = 8'($urandom);
      u = 1'($urandom);
      lk = !u && (a == 8'h20 || a == 8'h21);
      host.wr(a, d, u);
      chk("refused", reg_wr_refused_out, lk);
      if (a == 8'h1B)
        m_volt = d[5:0];
      if (u && a == 8'h20)
        m_sel[7:0] = d;
      if (u && a == 8'h21)
        {m_scale, m_sel[8]} = {d[7], d[0]};
      host.rd(a, q);
      chk("read back", q, rd_f(a));
      chk("select", {gap_select_out, powerdown_gap_scale_out},
          {m_sel, m_scale});
    end
    repeat (12) @(negedge sys_clk_in);
    chk("blank idle", monitor_blank_out, 1'b0);
    host.wr(8'h1B, 8'h05, 1'b1);
    n = 0;
    while (monitor_blank_out && n < 20)
    begin
      n++;
      @(negedge sys_clk_in);
    end
    chk("blank length", n, 8);
    for (int s = 0; s < 2; s++)
    begin
      d = 8'($urandom) & 8'hFE;
      host.wr(8'h20, d, 1'b1);
      m_sel[7:0] = d;
      d = {s[0], 6'h00, 1'($urandom)};
      host.wr(8'h21, d, 1'b1);
      {m_scale, m_sel[8]} = {d[7], d[0]};
      for (int i = 1; i < 11; i++)
      begin
        gap_index_in = 4'(i);
        power_down_in = (i == 1) ? 1'b0 : 1'($urandom);
        gap_start_in = 1'b1;
        @(negedge sys_clk_in);
        gap_start_in = 1'b0;
        n = 0;
        while (!gap_done_out && n < 200)
        begin
          @(negedge sys_clk_in);
          n++;
        end
        chk("gap len", n, len_f(gap_index_in, power_down_in));
      end
    end
    test_done;
  end
endmodule

bind rsd_regs rsd_regs_props u_props (.*);

// [test/rsd_regs_props.sv]
// Concurrent checks on the register bank ports
`timescale 1ns/1ns
`include "rsd_defs.vh"
module rsd_regs_props
(
  // All ports of the bank
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [7:0]  reg_addr_in,
  input wire logic [7:0]  reg_wdata_in,
  input wire logic [7:0]  reg_rdata_out,
  input wire logic        reg_wr_refused_out,
  input wire logic        unlock_in,
  input wire logic [5:0]  aux_regulator_voltage_out,
  input wire logic [11:0] aux_voltage_mv_out,
  input wire logic        monitor_blank_out,
  input wire logic [8:0]  gap_select_out,
  input wire logic        powerdown_gap_scale_out,
  input wire logic        gap_start_in,
  input wire logic [3:0]  gap_index_in,
  input wire logic        power_down_in,
  input wire logic        gap_busy_out,
  input wire logic        gap_done_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rstn_in);
  wire lo_w   = reg_addr_in == `RSD_ADDR_SEQ_LOW;
  wire hi_w   = reg_addr_in == `RSD_ADDR_SEQ_HIGH;
  wire lock_w = reg_wr_in && !unlock_in && (lo_w || hi_w);
  wire open_w = reg_wr_in && unlock_in;
  wire volt_w = reg_wr_in && reg_addr_in == `RSD_ADDR_AUX_VOLT;
  function automatic logic [11:0] mv_f(input logic [5:0] c);
    return (c <= 6'h19) ? 12'h384 + 12'h019 * c
                        : 12'h60E + 12'h032 * (c - 6'h1A);
  endfunction
  sequence blank_arm_s;
    volt_w ##1 !volt_w [*8];
  endsequence
  // Short gap is four cycles in the bench build
  sequence gap_short_s;
    gap_start_in && gap_index_in == 4'h1 && !gap_select_out[0]
      && !power_down_in ##1 !gap_start_in [*4];
  endsequence
  a_refuse_pulse: assert property (
    1'b1 |=> reg_wr_refused_out == $past(lock_w)) else $error("refused");
  a_low_write: assert property (
    open_w && lo_w |=> gap_select_out[7:0] == $past(reg_wdata_in))
    else $error("low write");
  a_high_write: assert property (
    open_w && hi_w |=> {powerdown_gap_scale_out, gap_select_out[8]}
      == {$past(reg_wdata_in[7]), $past(reg_wdata_in[0])})
    else $error("high write");
  a_locked_hold: assert property (
    lock_w |=> $stable({powerdown_gap_scale_out, gap_select_out}))
    else $error("locked write landed");
  a_volt_write: assert property (
    volt_w |=> aux_regulator_voltage_out == $past(reg_wdata_in[5:0]))
    else $error("code write");
  a_volt_read: assert property (
    reg_rd_in && reg_addr_in == `RSD_ADDR_AUX_VOLT
      |=> reg_rdata_out == {2'b00, $past(aux_regulator_voltage_out)})
    else $error("code read");
  a_mv_decode: assert property (
    $past(rstn_in) |-> aux_voltage_mv_out
      == mv_f($past(aux_regulator_voltage_out))) else $error("decode");
  a_blank_hold: assert property (
    volt_w |=> monitor_blank_out [*8]) else $error("blank short");
  a_blank_end: assert property (
    blank_arm_s |=> !monitor_blank_out) else $error("blank long");
  a_gap_short: assert property (
    gap_short_s |=> gap_done_out && !gap_busy_out) else $error("gap");
  a_gap_busy: assert property (
    gap_start_in |=> gap_busy_out && !gap_done_out) else $error("gap busy");
endmodule
